//--- inc/alm_consts.svh
// Constants of the accumulation map lookup block: command codes, table codes,
// flag states, entry layout and table limits.
// Assumes it is included by bare name wherever these values are needed.
`ifndef ALM_CONSTS_SVH
`define ALM_CONSTS_SVH

// Host command code that selects the global bank.
`define ALM_BANK_CMD      8'h25

// Table select codes of the tables held in this block.
`define ALM_TS_FBL        4'h4
`define ALM_TS_FAM        4'h5
`define ALM_TS_FVA        4'h6
`define ALM_TS_BAM        4'h7
`define ALM_TS_BVA        4'h8

// Last defined hardware baseline; entries above it are padding.
`define ALM_LAST_BASELINE 8'hd7

// Bookkeeping entry count, flag states and last byte of a block.
`define ALM_CK_ENTRIES    540
`define ALM_FLAG_UNUSED   4'h0
`define ALM_FLAG_PEND     4'h1
`define ALM_FLAG_OK       4'h2
`define ALM_FLAG_BAD      4'h4
`define ALM_BLOCK_LAST    8'hff

// Byte positions inside one eight byte bookkeeping entry.
`define ALM_EB_FLAG       3'h0
`define ALM_EB_BLOCK      3'h1
`define ALM_EB_PRED_HI    3'h2
`define ALM_EB_PRED_LO    3'h3
`define ALM_EB_ACT_HI     3'h4
`define ALM_EB_ACT_LO     3'h5

`endif

//--- inc/alm_pkg.sv
// Types shared by the accumulation map lookup modules.
// Assumes nothing of its surroundings.
package alm_pkg;
    // States of the checksum scan.
    typedef enum logic [1:0] {
        ALM_CK_IDLE,
        ALM_CK_SEARCH,
        ALM_CK_SUM,
        ALM_CK_STORE
    } alm_ck_state_type;
endpackage

//--- inc/alm_rd_if.sv
// Table read path between the checksum scan and the lookup tables.
// Assumes the table owner answers the read in the same cycle.
interface alm_rd_if;
    logic [3:0]  sel;
    logic [10:0] addr;
    logic [7:0]  data;
    modport chk (output sel, output addr, input data);
    modport tbl (input sel, input addr, output data);
endinterface

//--- hw/alm_chk.sv
// Checksum bookkeeping buffer and the scan that checks downloaded blocks.
// Assumes the table read path answers combinationally and a single clock.
`include "alm_consts.svh"
module alm_chk #(
    parameter int ENTRIES = `ALM_CK_ENTRIES
) (
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ck_wr_in,
    input  wire logic [15:0] ck_offset_in,
    input  wire logic [7:0]  ck_flag_in,
    input  wire logic [7:0]  ck_block_in,
    input  wire logic [15:0] ck_pred_in,
    input  wire logic        tick_in,
    input  wire logic        download_pending_in,
    input  wire logic [9:0]  ck_rd_idx_in,
    input  wire logic [2:0]  ck_rd_byte_in,
    alm_rd_if.chk            rd,
    output logic             ck_busy_out,
    output logic [7:0]       ck_rd_data_out
);
    alm_pkg::alm_ck_state_type state_q, state_d;
    logic [9:0]  idx_q, idx_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [15:0] sum_q, sum_d;
    logic [7:0]  rdd_d;
    logic        store_we;
    logic [3:0]  store_nib;
    logic [9:0]  hidx;
    logic        host_we;
    logic [7:0]  flag_q  [ENTRIES];
    logic [7:0]  block_m [ENTRIES];
    logic [15:0] pred_m  [ENTRIES];
    logic [15:0] act_m   [ENTRIES];

    // Host byte offset is turned into an entry index.
    assign hidx    = ck_offset_in[12:3];
    assign host_we = ck_wr_in && (int'(hidx) < ENTRIES);
    // The block under check is read from its own table.
    assign rd.sel  = flag_q[idx_q][7:4];
    assign rd.addr = {block_m[idx_q][2:0], cnt_q};

    // Scan sequencing and checksum accumulation.
    always_comb begin
        state_d   = state_q;
        idx_d     = idx_q;
        cnt_d     = cnt_q;
        sum_d     = sum_q;
        store_we  = 1'b0;
        store_nib = (sum_q == pred_m[idx_q]) ? `ALM_FLAG_OK : `ALM_FLAG_BAD;
        unique case (state_q)
            alm_pkg::ALM_CK_IDLE: begin
                if (tick_in && !download_pending_in) begin
                    idx_d   = 10'h000;
                    state_d = alm_pkg::ALM_CK_SEARCH;
                end
            end
            alm_pkg::ALM_CK_SEARCH: begin
                if (flag_q[idx_q][3:0] == `ALM_FLAG_PEND) begin
                    cnt_d   = 8'h00;
                    sum_d   = 16'h0000;
                    state_d = alm_pkg::ALM_CK_SUM;
                end else if (int'(idx_q) == ENTRIES - 1) begin
                    state_d = alm_pkg::ALM_CK_IDLE;
                end else begin
                    idx_d = idx_q + 10'h001;
                end
            end
            alm_pkg::ALM_CK_SUM: begin
                sum_d = sum_q + {8'h00, rd.data};
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == `ALM_BLOCK_LAST) begin
                    state_d = alm_pkg::ALM_CK_STORE;
                end
            end
            alm_pkg::ALM_CK_STORE: begin
                store_we = 1'b1;
                state_d  = alm_pkg::ALM_CK_IDLE;
            end
        endcase
    end

    // Status byte read back by entry index and byte position.
    always_comb begin
        rdd_d = 8'h00;
        if (int'(ck_rd_idx_in) < ENTRIES) begin
            unique case (ck_rd_byte_in)
                `ALM_EB_FLAG:    rdd_d = flag_q[ck_rd_idx_in];
                `ALM_EB_BLOCK:   rdd_d = block_m[ck_rd_idx_in];
                `ALM_EB_PRED_HI: rdd_d = pred_m[ck_rd_idx_in][15:8];
                `ALM_EB_PRED_LO: rdd_d = pred_m[ck_rd_idx_in][7:0];
                `ALM_EB_ACT_HI:  rdd_d = act_m[ck_rd_idx_in][15:8];
                `ALM_EB_ACT_LO:  rdd_d = act_m[ck_rd_idx_in][7:0];
                default:         rdd_d = 8'h00;
            endcase
        end
    end

    // Scan state and output registers.
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q        <= alm_pkg::ALM_CK_IDLE;
            idx_q          <= 10'h000;
            cnt_q          <= 8'h00;
            sum_q          <= 16'h0000;
            ck_busy_out    <= 1'b0;
            ck_rd_data_out <= 8'h00;
        end else begin
            state_q        <= state_d;
            idx_q          <= idx_d;
            cnt_q          <= cnt_d;
            sum_q          <= sum_d;
            ck_busy_out    <= (state_d != alm_pkg::ALM_CK_IDLE);
            ck_rd_data_out <= rdd_d;
        end
    end

    // Flags start cleared; a new download wins over a result in the same cycle.
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < ENTRIES; i++) begin
                flag_q[i] <= 8'h00;
            end
        end else if (host_we) begin
            flag_q[hidx] <= ck_flag_in;
        end else if (store_we) begin
            flag_q[idx_q] <= {flag_q[idx_q][7:4], store_nib};
        end
    end

    // Entry payload storage.
    always_ff @(posedge clock_in) begin
        if (host_we) begin
            block_m[hidx] <= ck_block_in;
            pred_m[hidx]  <= ck_pred_in;
        end
        if (store_we) begin
            act_m[idx_q] <= sum_q;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence scan_go;
        state_q == alm_pkg::ALM_CK_IDLE && tick_in && !download_pending_in;
    endsequence

    scan_start_a: assert property (scan_go |=> state_q == alm_pkg::ALM_CK_SEARCH
        && idx_q == 10'h000) else $error("Scan did not start on tick.");
    store_ok_a: assert property (state_q == alm_pkg::ALM_CK_STORE && !host_we
        && sum_q == pred_m[idx_q] |=> flag_q[$past(idx_q)][3:0] == `ALM_FLAG_OK)
        else $error("Matching checksum not flagged good.");
    store_bad_a: assert property (state_q == alm_pkg::ALM_CK_STORE && !host_we
        && sum_q != pred_m[idx_q] |=> flag_q[$past(idx_q)][3:0] == `ALM_FLAG_BAD)
        else $error("Mismatching checksum not flagged bad.");
    host_entry_a: assert property (host_we |=> flag_q[$past(hidx)] == $past(ck_flag_in)
        && pred_m[$past(hidx)] == $past(ck_pred_in)) else $error("Entry not stored.");
    sum_end_a: assert property (state_q == alm_pkg::ALM_CK_SUM && cnt_q == 8'hff
        |=> state_q == alm_pkg::ALM_CK_STORE ##1 state_q == alm_pkg::ALM_CK_IDLE)
        else $error("Block sum length wrong.");
endmodule

//--- hw/alm_lookup.sv
// Top of the accumulation map lookup: bank select, five bank-selected tables,
// front and back end lookups, and the checksum bookkeeping buffer.
// Assumes a host that loads tables byte by byte and keeps its loading rules.
`include "alm_consts.svh"
// What this block does
// - One global bank select for all five tables.
// - Map bits 6-4 give normal accumulation code.
// - Front low nibble selects input mapping table.
// - Front redirect bit takes validity accumulation code.
// - Back low nibble selects back mapping table.
// - Back redirect bit takes back validity code.
// - Back map indexed by bank and baseline.
// - Validity tables indexed bank, type, low field.
// - Tape validity code is bits 2-0.
// - Front validity code picks accumulation bank.
// - Back validity code picks readout bank.
// - Checksum per block, one entry per block.
// - Entry holds flag, block, predicted, actual.
// - Flag upper nibble holds table code.
// - Flag states unused, pending, checked good.
// - Mismatch sets flag lower nibble to four.
// - Tick scan checks first pending entry.
module alm_lookup (
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        cmd_wr_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic [7:0]  cmd_data_in,
    input  wire logic        tbl_wr_in,
    input  wire logic [3:0]  tbl_sel_in,
    input  wire logic [10:0] tbl_addr_in,
    input  wire logic [7:0]  tbl_data_in,
    input  wire logic        fe_req_in,
    input  wire logic [7:0]  fe_baseline_number_in,
    input  wire logic [7:0]  fe_spec_in,
    input  wire logic        be_req_in,
    input  wire logic [7:0]  be_baseline_number_in,
    input  wire logic [7:0]  be_spec_in,
    input  wire logic        ck_wr_in,
    input  wire logic [15:0] ck_offset_in,
    input  wire logic [7:0]  ck_flag_in,
    input  wire logic [7:0]  ck_block_in,
    input  wire logic [15:0] ck_pred_in,
    input  wire logic        tick_in,
    input  wire logic        download_pending_in,
    input  wire logic [9:0]  ck_rd_idx_in,
    input  wire logic [2:0]  ck_rd_byte_in,
    output logic [1:0]       bank_out,
    output logic             fe_valid_out,
    output logic [7:0]       fe_baseline_out,
    output logic [2:0]       fe_accum_out,
    output logic [3:0]       fe_map_out,
    output logic             be_valid_out,
    output logic [2:0]       be_accum_out,
    output logic [3:0]       be_map_out,
    output logic             ck_busy_out,
    output logic [7:0]       ck_rd_data_out
);
    logic [7:0] front_baseline_table       [1024];
    logic [7:0] front_accum_map_table      [1024];
    logic [7:0] front_validity_accum_table [2048];
    logic [7:0] back_accum_map_table       [1024];
    logic [7:0] back_validity_accum_table  [2048];

    logic [1:0]  bank_d;
    logic [7:0]  fe_map_byte, fe_vacc_byte, be_map_byte, be_vacc_byte;
    logic [10:0] fe_vidx, be_vidx;
    logic        fe_def, be_def;
    logic        fe_valid_d, be_valid_d;
    logic [7:0]  fe_baseline_d;
    logic [2:0]  fe_accum_d, be_accum_d;
    logic [3:0]  fe_map_d, be_map_d;

    alm_rd_if rd_bus ();

    // Byte read of one of the tables for the checksum scan.
    function automatic logic [7:0] read_table(input logic [3:0] sel, input logic [10:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (sel)
            `ALM_TS_FBL: v = front_baseline_table[a[9:0]];
            `ALM_TS_FAM: v = front_accum_map_table[a[9:0]];
            `ALM_TS_FVA: v = front_validity_accum_table[a];
            `ALM_TS_BAM: v = back_accum_map_table[a[9:0]];
            `ALM_TS_BVA: v = back_validity_accum_table[a];
            default:     v = 8'h00;
        endcase
        return v;
    endfunction

    // A process, so a byte reloaded under a steady address is seen at once.
    always_comb begin
        rd_bus.data = read_table(rd_bus.sel, rd_bus.addr);
    end

    // Host loads of the tables; the bank bits sit above the baseline field.
    always_ff @(posedge clock_in) begin
        if (tbl_wr_in) begin
            case (tbl_sel_in)
                `ALM_TS_FBL: front_baseline_table[tbl_addr_in[9:0]]  <= tbl_data_in;
                `ALM_TS_FAM: front_accum_map_table[tbl_addr_in[9:0]] <= tbl_data_in;
                `ALM_TS_FVA: front_validity_accum_table[tbl_addr_in] <= tbl_data_in;
                `ALM_TS_BAM: back_accum_map_table[tbl_addr_in[9:0]]  <= tbl_data_in;
                `ALM_TS_BVA: back_validity_accum_table[tbl_addr_in]  <= tbl_data_in;
                default: ;
            endcase
        end
    end

    // Global bank select taken from the bank command.
    always_comb begin
        bank_d = bank_out;
        if (cmd_wr_in && cmd_code_in == `ALM_BANK_CMD) begin
            bank_d = cmd_data_in[1:0];
        end
    end

    // Table reads; map code parity tells tape from pulsar validities.
    always_comb begin
        fe_def       = (fe_baseline_number_in <= `ALM_LAST_BASELINE);
        be_def       = (be_baseline_number_in <= `ALM_LAST_BASELINE);
        fe_map_byte  = front_accum_map_table[{bank_out, fe_baseline_number_in}];
        be_map_byte  = back_accum_map_table[{bank_out, be_baseline_number_in}];
        fe_vidx      = {bank_out, fe_map_byte[0],
                        fe_map_byte[0] ? fe_spec_in : fe_baseline_number_in};
        be_vidx      = {bank_out, be_map_byte[0],
                        be_map_byte[0] ? be_spec_in : be_baseline_number_in};
        fe_vacc_byte = front_validity_accum_table[fe_vidx];
        be_vacc_byte = back_validity_accum_table[be_vidx];
    end

    // Next lookup results; padding baselines give zero codes.
    always_comb begin
        fe_valid_d    = fe_req_in;
        be_valid_d    = be_req_in;
        fe_baseline_d = fe_baseline_out;
        fe_accum_d    = fe_accum_out;
        fe_map_d      = fe_map_out;
        be_accum_d    = be_accum_out;
        be_map_d      = be_map_out;
        if (fe_req_in) begin
            fe_baseline_d = fe_def ? front_baseline_table[{bank_out, fe_baseline_number_in}]
                                   : 8'h00;
            fe_map_d      = fe_def ? fe_map_byte[3:0] : 4'h0;
            if (!fe_def) begin
                fe_accum_d = 3'h0;
            end else if (fe_map_byte[3]) begin
                fe_accum_d = fe_vacc_byte[2:0];
            end else begin
                fe_accum_d = fe_map_byte[6:4];
            end
        end
        if (be_req_in) begin
            be_map_d = be_def ? be_map_byte[3:0] : 4'h0;
            if (!be_def) begin
                be_accum_d = 3'h0;
            end else if (be_map_byte[3]) begin
                be_accum_d = be_vacc_byte[2:0];
            end else begin
                be_accum_d = be_map_byte[6:4];
            end
        end
    end

    // Registers of bank select and lookup outputs.
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bank_out        <= 2'h0;
            fe_valid_out    <= 1'b0;
            fe_baseline_out <= 8'h00;
            fe_accum_out    <= 3'h0;
            fe_map_out      <= 4'h0;
            be_valid_out    <= 1'b0;
            be_accum_out    <= 3'h0;
            be_map_out      <= 4'h0;
        end else begin
            bank_out        <= bank_d;
            fe_valid_out    <= fe_valid_d;
            fe_baseline_out <= fe_baseline_d;
            fe_accum_out    <= fe_accum_d;
            fe_map_out      <= fe_map_d;
            be_valid_out    <= be_valid_d;
            be_accum_out    <= be_accum_d;
            be_map_out      <= be_map_d;
        end
    end

    // Checksum bookkeeping buffer and scan.
    alm_chk u_chk (
        .clock_in            (clock_in),
        .sys_rst_in          (sys_rst_in),
        .ck_wr_in            (ck_wr_in),
        .ck_offset_in        (ck_offset_in),
        .ck_flag_in          (ck_flag_in),
        .ck_block_in         (ck_block_in),
        .ck_pred_in          (ck_pred_in),
        .tick_in             (tick_in),
        .download_pending_in (download_pending_in),
        .ck_rd_idx_in        (ck_rd_idx_in),
        .ck_rd_byte_in       (ck_rd_byte_in),
        .rd                  (rd_bus.chk),
        .ck_busy_out         (ck_busy_out),
        .ck_rd_data_out      (ck_rd_data_out)
    );

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    bank_sel_a: assert property (cmd_wr_in && cmd_code_in == 8'h25
        |=> bank_out == $past(cmd_data_in[1:0])) else $error("Bank not selected.");
    fe_norm_a: assert property (fe_req_in && fe_def && !fe_map_byte[3]
        |=> fe_valid_out && fe_accum_out == $past(fe_map_byte[6:4]))
        else $error("Front normal accumulation code wrong.");
    fe_map_a: assert property (fe_req_in && fe_def
        |=> fe_map_out == $past(fe_map_byte[3:0])) else $error("Front map code wrong.");
    fe_redir_a: assert property (fe_req_in && fe_def && fe_map_byte[3]
        |=> fe_accum_out == $past(fe_vacc_byte[2:0])) else $error("Front redirect wrong.");
    be_map_a: assert property (be_req_in && be_def
        |=> be_valid_out && be_map_out == $past(be_map_byte[3:0]))
        else $error("Back map code wrong.");
    be_redir_a: assert property (be_req_in && be_def && be_map_byte[3]
        |=> be_accum_out == $past(be_vacc_byte[2:0])) else $error("Back redirect wrong.");
    pad_ignore_a: assert property (fe_req_in && !fe_def
        |=> fe_map_out == 4'h0 && fe_accum_out == 3'h0 && fe_baseline_out == 8'h00)
        else $error("Padding baseline affected result.");
    valid_hold_a: assert property (!fe_req_in
        |=> !fe_valid_out && $stable(fe_map_out)) else $error("Front result changed idle.");
endmodule

//--- testbench/alm_host_model.sv
// Host controller model that loads tables, bank commands and checksum entries.
// Assumes the bench calls its tasks from one process, one request at a time.
module alm_host_model (
    input  wire logic  clock_in,
    output logic       cmd_wr_out,
    output logic [7:0] cmd_code_out,
    output logic [7:0] cmd_data_out,
    output logic       tbl_wr_out,
    output logic [3:0] tbl_sel_out,
    output logic [10:0] tbl_addr_out,
    output logic [7:0] tbl_data_out,
    output logic       ck_wr_out,
    output logic [15:0] ck_offset_out,
    output logic [7:0] ck_flag_out,
    output logic [7:0] ck_block_out,
    output logic [15:0] ck_pred_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // All strobes are low and every line has a value at time zero.
    initial begin
        {cmd_wr_out, tbl_wr_out, ck_wr_out} = 3'h0;
        {cmd_code_out, cmd_data_out, tbl_sel_out, tbl_addr_out, tbl_data_out} = '0;
        {ck_offset_out, ck_flag_out, ck_block_out, ck_pred_out} = '0;
    end

    // Sends one host command for one cycle.
    task automatic send_cmd(input logic [7:0] code, input logic [7:0] data);
        @(posedge clock_in);
        {tbl_wr_out, ck_wr_out} <= 2'h0;
        cmd_wr_out   <= 1'b1;
        cmd_code_out <= code;
        cmd_data_out <= data;
    endtask

    // Writes one table byte; the caller keeps codes inside the loading limits.
    task automatic wr_tbl(input logic [3:0] sel, input logic [10:0] addr,
                          input logic [7:0] data);
        @(posedge clock_in);
        {cmd_wr_out, ck_wr_out} <= 2'h0;
        tbl_wr_out   <= 1'b1;
        tbl_sel_out  <= sel;
        tbl_addr_out <= addr;
        tbl_data_out <= data;
    endtask

    // Writes a whole aligned 256 byte block whose byte i holds i.
    task automatic wr_block(input logic [3:0] sel, input logic [2:0] blk);
        for (int i = 0; i < 256; i++) begin
            wr_tbl(sel, {blk, i[7:0]}, i[7:0]);
        end
    endtask

    // Stores the flag, block number and predicted sum of one bookkeeping entry.
    task automatic wr_entry(input logic [9:0] idx, input logic [7:0] flag,
                            input logic [7:0] blk, input logic [15:0] pred);
        @(posedge clock_in);
        {cmd_wr_out, tbl_wr_out} <= 2'h0;
        ck_wr_out     <= 1'b1;
        ck_offset_out <= {3'h0, idx, 3'h0};
        ck_flag_out   <= flag;
        ck_block_out  <= blk;
        ck_pred_out   <= pred;
    endtask

    // Releases the bus; table data and predicted sum lines flip so stale values never match.
    task automatic idle();
        @(posedge clock_in);
        {cmd_wr_out, tbl_wr_out, ck_wr_out} <= 3'h0;
        tbl_data_out <= ~tbl_data_out;
        ck_pred_out  <= ~ck_pred_out;
    endtask
endmodule

//--- testbench/accumulation_map_lookup_bench.sv
// Self-checking bench for the accumulation map lookup top.
// Assumes the host model drives the host side and this module the lookup side.
module accumulation_map_lookup_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_in = 1'b0, sys_rst_in = 1'b1, cmd_wr_in, tbl_wr_in, ck_wr_in;
    logic [7:0] cmd_code_in, cmd_data_in, tbl_data_in, ck_flag_in, ck_block_in;
    logic [3:0] tbl_sel_in;
    logic [10:0] tbl_addr_in;
    logic [15:0] ck_offset_in, ck_pred_in;
    logic fe_req_in = 1'b0, be_req_in = 1'b0, tick_in = 1'b0, download_pending_in = 1'b0;
    logic [7:0] fe_baseline_number_in = 8'h00, fe_spec_in = 8'h00;
    logic [7:0] be_baseline_number_in = 8'h00, be_spec_in = 8'h00;
    logic [9:0] ck_rd_idx_in = 10'h000;
    logic [2:0] ck_rd_byte_in = 3'h0;
    logic [1:0] bank_out;
    logic fe_valid_out, be_valid_out, ck_busy_out;
    logic [7:0] fe_baseline_out, ck_rd_data_out;
    logic [2:0] fe_accum_out, be_accum_out;
    logic [3:0] fe_map_out, be_map_out;
    int fail_count = 0;
    int check_count = 0;

    // Free running 40 MHz clock.
    always #12.5 clock_in = ~clock_in;

    alm_host_model host_u (.clock_in(clock_in), .cmd_wr_out(cmd_wr_in),
        .cmd_code_out(cmd_code_in), .cmd_data_out(cmd_data_in), .tbl_wr_out(tbl_wr_in),
        .tbl_sel_out(tbl_sel_in), .tbl_addr_out(tbl_addr_in), .tbl_data_out(tbl_data_in),
        .ck_wr_out(ck_wr_in), .ck_offset_out(ck_offset_in), .ck_flag_out(ck_flag_in),
        .ck_block_out(ck_block_in), .ck_pred_out(ck_pred_in));

    alm_lookup dut_u (.*);

    // Compares one value and reports a difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d.", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Front lookup; am holds the expected accumulation code above the map code.
    task automatic fe_look(input logic [7:0] bl, input logic [7:0] spec,
                           input logic [7:0] base, input logic [6:0] am);
        @(posedge clock_in);
        {fe_req_in, fe_baseline_number_in, fe_spec_in} <= {1'b1, bl, spec};
        @(posedge clock_in);
        fe_req_in <= 1'b0;
        #1 check({fe_valid_out, fe_baseline_out}, {1'b1, base});
        check({fe_accum_out, fe_map_out}, am);
    endtask

    // Back lookup with the same expectation layout.
    task automatic be_look(input logic [7:0] bl, input logic [7:0] spec,
                           input logic [6:0] am);
        @(posedge clock_in);
        {be_req_in, be_baseline_number_in, be_spec_in} <= {1'b1, bl, spec};
        @(posedge clock_in);
        be_req_in <= 1'b0;
        #1 check({be_valid_out, be_accum_out, be_map_out}, {1'b1, am});
    endtask

    // Reads one byte of a bookkeeping entry.
    task automatic rd_ck(input logic [9:0] idx, input logic [2:0] b, input logic [7:0] exp);
        @(posedge clock_in);
        {ck_rd_idx_in, ck_rd_byte_in} <= {idx, b};
        @(posedge clock_in);
        #1 check(ck_rd_data_out, exp);
    endtask

    // One tick pulse with the given download state; returns after it is taken.
    task automatic tick_once(input logic pend);
        @(posedge clock_in);
        {tick_in, download_pending_in} <= {1'b1, pend};
        @(posedge clock_in);
        tick_in <= 1'b0;
        #1;
    endtask

    // Waits a bounded time for the scan to finish.
    task automatic wait_idle();
        int n;
        n = 0;
        while (ck_busy_out !== 1'b0 && n < 2000) begin
            @(posedge clock_in);
            #1 n++;
        end
        check(ck_busy_out, 1'b0);
    endtask

    // Cuts a hang short.
    initial begin
        #150us;
        fail_count++;
        finish_test();
    end

    // Main test sequence.
    initial begin
        repeat (16) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        #1 check({bank_out, fe_valid_out, be_valid_out, ck_busy_out}, 5'h00);
        rd_ck(10'h000, 3'h0, 8'h00);
        $display("Test reset done.");
        host_u.send_cmd(8'h25, 8'h01);
        host_u.send_cmd(8'h26, 8'h03);
        host_u.idle();
        #1 check(bank_out, 2'h1);
        host_u.wr_tbl(4'h5, 11'h105, 8'h24);
        host_u.wr_tbl(4'h4, 11'h105, 8'h11);
        host_u.wr_tbl(4'h5, 11'h205, 8'h53);
        host_u.wr_tbl(4'h4, 11'h205, 8'h2a);
        host_u.wr_tbl(4'h5, 11'h2d2, 8'hfa);
        host_u.wr_tbl(4'h4, 11'h2d2, 8'hd2);
        host_u.wr_tbl(4'h6, 11'h4d2, 8'h06);
        host_u.wr_tbl(4'h5, 11'h2d3, 8'h5b);
        host_u.wr_tbl(4'h4, 11'h2d3, 8'hd3);
        for (int s = 0; s < 256; s++) begin
            host_u.wr_tbl(4'h6, {3'h5, s[7:0]}, 8'h02);
        end
        host_u.wr_tbl(4'h5, 11'h2dc, 8'h77);
        host_u.wr_tbl(4'h4, 11'h2dc, 8'h55);
        host_u.wr_tbl(4'h7, 11'h205, 8'h61);
        host_u.wr_tbl(4'h7, 11'h2d2, 8'hcc);
        host_u.wr_tbl(4'h8, 11'h4d2, 8'h03);
        host_u.idle();
        fe_look(8'h05, 8'h00, 8'h11, {3'h2, 4'h4});
        host_u.send_cmd(8'h25, 8'h02);
        host_u.idle();
        fe_look(8'h05, 8'h00, 8'h2a, {3'h5, 4'h3});
        fe_look(8'hd2, 8'h00, 8'hd2, {3'h6, 4'ha});
        fe_look(8'hd3, 8'h33, 8'hd3, {3'h2, 4'hb});
        fe_look(8'hdc, 8'h00, 8'h00, {3'h0, 4'h0});
        be_look(8'h05, 8'h00, {3'h6, 4'h1});
        be_look(8'hd2, 8'h00, {3'h3, 4'hc});
        $display("Test lookups done.");
        host_u.wr_block(4'h7, 3'h0);
        host_u.wr_entry(10'd256, 8'h21, 8'h00, 16'h0001);
        host_u.wr_entry(10'd528, 8'h71, 8'h00, 16'h7f80);
        host_u.idle();
        tick_once(1'b1);
        check(ck_busy_out, 1'b0);
        tick_once(1'b0);
        check(ck_busy_out, 1'b1);
        wait_idle();
        rd_ck(10'd256, 3'h0, 8'h24);
        rd_ck(10'd256, 3'h5, 8'h00);
        rd_ck(10'd528, 3'h0, 8'h71);
        tick_once(1'b0);
        wait_idle();
        rd_ck(10'd528, 3'h0, 8'h72);
        rd_ck(10'd528, 3'h4, 8'h7f);
        rd_ck(10'd528, 3'h5, 8'h80);
        rd_ck(10'd528, 3'h2, 8'h7f);
        rd_ck(10'd528, 3'h1, 8'h00);
        rd_ck(10'd528, 3'h6, 8'h00);
        tick_once(1'b0);
        check(ck_busy_out, 1'b1);
        wait_idle();
        rd_ck(10'd256, 3'h0, 8'h24);
        $display("Test checksum done.");
        finish_test();
    end
endmodule
